//--- dv/gate_inject_monitor.sv
// assertion checker for the event gate and injection block
// bound to the design top, sees only its ports
`timescale 1ns/1ns
`include "gate_inject_consts.vh"
module gate_inject_monitor (
   // clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // watched inputs
   input wire set_gate_instr_i,
   input wire clear_gate_instr_i,
   input wire bp_match_i,
   input wire int_smi_i,
   input wire hypervisor_call_instr_i,
   // watched outputs
   input wire global_event_gate_o,
   input wire dbg_take_o,
   input wire smi_take_o,
   input wire restart_take_o,
   input wire security_exception_o,
   input wire nmi_take_o,
   input wire maskable_interrupt_take_o,
   input wire virtual_maskable_interrupt_take_o,
   input wire mcheck_take_o,
   input wire shutdown_o,
   input wire undefined_opcode_fault_o,
   input wire hcall_exit_o,
   input wire inj_deliver_o,
   input wire entry_fail_o,
   input wire [2:0] inj_type_o,
   input wire [7:0] inj_vector_o,
   input wire [31:0] exit_code_o
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   a_gate_set: assert property (set_gate_instr_i |-> ##2 global_event_gate_o)
      else $error("gate not set");
   a_gate_clr: assert property (clear_gate_instr_i && !set_gate_instr_i |-> ##2
      !global_event_gate_o) else $error("gate not cleared");
   a_bp_gate: assert property (bp_match_i |=> dbg_take_o == global_event_gate_o)
      else $error("debug trap vs gate");
   a_smi_drop: assert property (int_smi_i ##1 !global_event_gate_o |-> !smi_take_o)
      else $error("internal smi taken");
   a_held_gate: assert property (nmi_take_o || maskable_interrupt_take_o || virtual_maskable_interrupt_take_o || restart_take_o
      |-> global_event_gate_o) else $error("held event taken");
   a_sec_gate: assert property (security_exception_o |-> global_event_gate_o)
      else $error("security exception gate low");
   a_one_deliver: assert property ($onehot0({mcheck_take_o, restart_take_o, nmi_take_o,
      maskable_interrupt_take_o, virtual_maskable_interrupt_take_o})) else $error("two held events");
   a_shut_sticky: assert property (shutdown_o |=> shutdown_o)
      else $error("shutdown lost");
   a_hcall_one: assert property (hypervisor_call_instr_i |=>
      undefined_opcode_fault_o != hcall_exit_o) else $error("call outcome");
   a_fail_code: assert property (entry_fail_o |-> exit_code_o == `INVALID_EXIT)
      else $error("exit code");
   a_nmi_vec: assert property (inj_deliver_o && inj_type_o == `TYPE_NMI |->
      inj_vector_o == 8'h00) else $error("nmi vector");
   c_sec: cover property (security_exception_o);
   c_fail: cover property (entry_fail_o);
   c_shut: cover property (shutdown_o);
endmodule // gate_inject_monitor

//--- dv/guest_event_gating_injection_bench.sv
// self-checking bench for the event gate and injection block
// drives the design ports directly; checker bound at the foot
`timescale 1ns/1ns
`include "gate_inject_consts.vh"
module guest_event_gating_injection_bench;
   // ****
   // signals
   // ****
   logic core_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, restart_redirect_i = 0;
   logic debug_request_pin_i = 0, address_bit20_mask_i = 0, guest_64bit_i = 0;
   logic [7:0] addr_i = 0;
   logic [31:0] wdata_i = 0, order;
   logic [17:0] pv = 0;
   wire mcheck_i, restart_sig_i, ext_smi_i, nmi_i, maskable_interrupt_i;
   wire virtual_maskable_interrupt_i, bp_match_i, int_smi_i, trace_flag_trap_i;
   wire hw_reset_evt_i, housekeeping_i, set_gate_instr_i, clear_gate_instr_i;
   wire hypervisor_call_instr_i, guest_entry_instr_i, resume_from_mgmt_instr_i;
   wire nmi_return_i, delivery_fault_i;
   wire [31:0] rdata_o, pushed_error_value_o, exit_code_o;
   wire [2:0] inj_type_o;
   wire [7:0] inj_vector_o;
   wire global_event_gate_o, dbg_take_o, trace_take_o, reset_take_o, housekeep_take_o;
   wire restart_take_o, security_exception_o, smi_take_o, nmi_take_o, maskable_interrupt_take_o;
   wire virtual_maskable_interrupt_take_o, mcheck_take_o, shutdown_o, debug_enter_o, a20_mask_o;
   wire undefined_opcode_fault_o, hcall_exit_o, paged_real_o, inj_deliver_o;
   wire inj_err_push_o, inj_dpl_check_o, inj_skip_icpt_o, sec_exc_exit_o, entry_fail_o;
   int n_mismatch = 0, checked = 0, cyc = 0, i;
   typedef struct packed {logic [31:0] lo; logic [2:0] f;} row_t;
   // f: wide guest, delivered, failed
   row_t rows [0:14] = '{'{32'h8000_0b0e, 3'h2}, '{32'h8000_030e, 3'h2},
      '{32'h8000_0202, 3'h2}, '{32'h8000_0020, 3'h2}, '{32'h8000_0480, 3'h2},
      '{32'h8000_0303, 3'h2}, '{32'h8000_0304, 3'h2}, '{32'h8000_0305, 3'h2},
      '{32'h8000_0103, 3'h1}, '{32'h8000_0500, 3'h1}, '{32'h8000_0700, 3'h1},
      '{32'h8000_0302, 3'h1}, '{32'h8000_0320, 3'h1}, '{32'h8000_0305, 3'h5},
      '{32'h0000_030e, 3'h0}};
   // pulse bits, high to low
   assign {mcheck_i, restart_sig_i, ext_smi_i, nmi_i, maskable_interrupt_i,
      virtual_maskable_interrupt_i, bp_match_i, int_smi_i, trace_flag_trap_i,
      hw_reset_evt_i, housekeeping_i, set_gate_instr_i, clear_gate_instr_i,
      hypervisor_call_instr_i, guest_entry_instr_i, resume_from_mgmt_instr_i,
      nmi_return_i, delivery_fault_i} = pv;
   guest_event_gating_injection guest_event_gating_injection_inst (.*);
   always #10 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc > 3000) begin
         n_mismatch++;
         report_and_stop;
      end
   end
   // ****
   // tasks
   // ****
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1;
      @(posedge core_clk_i);
      wr_i <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1;
      @(posedge core_clk_i);
      rd_i <= 0;
      @(negedge core_clk_i);
      chk(rdata_o, e);
   endtask
   task automatic pulse(input logic [17:0] m);
      @(posedge core_clk_i);
      pv <= m;
      @(posedge core_clk_i);
      pv <= 0;
   endtask
   task automatic settle;
      @(negedge core_clk_i);
   endtask
   // codes of held deliveries in the order seen
   task automatic watch(input int n);
      order = 0;
      repeat (n) begin
         @(negedge core_clk_i);
         if (mcheck_take_o === 1'b1) order = {order[27:0], 4'h1};
         if (nmi_take_o === 1'b1) order = {order[27:0], 4'h2};
         if (maskable_interrupt_take_o === 1'b1) order = {order[27:0], 4'h3};
         if (virtual_maskable_interrupt_take_o === 1'b1) order = {order[27:0], 4'h4};
         if (security_exception_o === 1'b1) order = {order[27:0], 4'h5};
         if (restart_take_o === 1'b1) order = {order[27:0], 4'h6};
         if (smi_take_o === 1'b1) order = {order[27:0], 4'h7};
      end
   endtask
   task report_and_stop;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      repeat (10) @(posedge core_clk_i);
      chk(global_event_gate_o, 1);
      chk(shutdown_o, 0);
      resetn_i <= 1;
      rd(`OFF_CTRL, `CTRL_RST);
      rd(`OFF_STATUS, 32'h1);
      wr(`OFF_STATUS, 32'hffff_ffff);
      rd(`OFF_STATUS, 32'h1);
      rd(8'h20, 32'h0);
      wr(`OFF_INJ_HI, 32'h1234);
      for (i = 0; i < 15; i++) begin
         wr(`OFF_INJ_LO, rows[i].lo);
         guest_64bit_i <= rows[i].f[2];
         pulse(18'h00008);
         settle;
         chk(inj_deliver_o, rows[i].f[1]);
         chk(entry_fail_o, rows[i].f[0]);
         if (rows[i].f[0]) chk(exit_code_o, `INVALID_EXIT);
         if (rows[i].f[1]) begin
            chk(inj_type_o, rows[i].lo[10:8]);
            chk(inj_vector_o, rows[i].lo[10:8] == 3'h2 ? 8'h00 : rows[i].lo[7:0]);
            chk(inj_err_push_o, rows[i].lo[11]);
            if (rows[i].lo[11]) chk(pushed_error_value_o, 32'h1234);
            chk(inj_dpl_check_o, rows[i].lo[10:0] == 11'h303 ||
               rows[i].lo[10:0] == 11'h304);
            chk(inj_skip_icpt_o, 1);
         end
      end
      pulse(18'h04800);
      watch(4);
      chk(order, 32'h2);
      pulse(18'h04000);
      watch(4);
      chk(order, 32'h0);
      pulse(18'h00002);
      watch(4);
      chk(order, 32'h2);
      pulse(18'h00010);
      settle;
      chk(undefined_opcode_fault_o, 1);
      chk(hcall_exit_o, 0);
      wr(`OFF_CTRL, 32'h1c);
      pulse(18'h00011);
      settle;
      chk(hcall_exit_o, 1);
      chk(sec_exc_exit_o, 1);
      @(posedge core_clk_i);
      debug_request_pin_i <= 1;
      address_bit20_mask_i <= 1;
      pulse(18'h00022);
      pulse(18'h2ff80);
      settle;
      chk({dbg_take_o, smi_take_o, nmi_take_o, maskable_interrupt_take_o}, 0);
      chk({trace_take_o, reset_take_o, housekeep_take_o}, 3'h7);
      chk({debug_enter_o, a20_mask_o}, 2'h3);
      pulse(18'h00040);
      watch(8);
      chk(order, 32'h0001_7234);
      @(posedge core_clk_i);
      restart_redirect_i <= 1;
      pulse(18'h10000);
      watch(4);
      chk(order, 32'h5);
      @(posedge core_clk_i);
      restart_redirect_i <= 0;
      pulse(18'h10000);
      watch(4);
      chk(order, 32'h6);
      wr(`OFF_CTRL, 32'hffff_ffff);
      rd(`OFF_CTRL, 32'h1f);
      chk({debug_enter_o, a20_mask_o}, 2'h0);
      wr(`OFF_INJ_LO, 32'h0);
      wr(`OFF_CR0_IMG, 32'h8000_0000);
      pulse(18'h00008);
      settle;
      chk(paged_real_o, 1);
      chk({inj_deliver_o, entry_fail_o}, 0);
      wr(`OFF_CR0_IMG, 32'h8000_0001);
      pulse(18'h00004);
      settle;
      chk(paged_real_o, 0);
      wr(`OFF_CTRL, 32'h0);
      pulse(18'h00020);
      pulse(18'h20000);
      settle;
      chk(shutdown_o, 1);
      rd(`OFF_STATUS, 32'h0000_0480);
      rd(`OFF_EXIT, `INVALID_EXIT);
      @(posedge core_clk_i);
      resetn_i <= 0;
      settle;
      chk(shutdown_o, 0);
      chk(global_event_gate_o, 1);
      @(posedge core_clk_i);
      resetn_i <= 1;
      rd(`OFF_STATUS, 32'h0000_0001);
      rd(`OFF_CTRL, `CTRL_RST);
      report_and_stop;
   end
endmodule // guest_event_gating_injection_bench
bind guest_event_gating_injection gate_inject_monitor mon_inst (.*);

//--- hdl/gate_inject_consts.vh
// constants for the event gate and injection block
// assumes a 32-bit register port with byte offsets
`ifndef GATE_INJECT_CONSTS_VH
`define GATE_INJECT_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define OFF_CTRL 8'h00
`define OFF_INJ_LO 8'h04
`define OFF_INJ_HI 8'h08
`define OFF_CR0_IMG 8'h0c
`define OFF_STATUS 8'h10
`define OFF_EXIT 8'h14
// ****************************************
// control register fields
// ****************************************
`define CTRL_DPD 0
`define CTRL_DIS_ADDRESS_BIT20_MASK 1
`define CTRL_MC_HOLD 2
`define CTRL_HCALL_ICPT 3
`define CTRL_EXC_ICPT 4
`define CTRL_W 5
`define CTRL_RST 5'h04
// ****************************************
// injection field layout
// ****************************************
`define INJ_VEC_HI 7
`define INJ_VEC_LO 0
`define INJ_TYPE_HI 10
`define INJ_TYPE_LO 8
`define INJ_EV 11
`define INJ_VALID 31
`define TYPE_MASKABLE_INTERRUPT 3'h0
`define TYPE_NMI 3'h2
`define TYPE_EXC 3'h3
`define TYPE_SWINT 3'h4
`define VEC_NMI 8'h02
`define VEC_BP 8'h03
`define VEC_OF 8'h04
`define VEC_BR 8'h05
`define VEC_RSVD 8'h0f
`define VEC_EXC_MAX 8'h1f
// ****************************************
// control register zero image fields
// ****************************************
`define CR0_PE 0
`define CR0_PG 31
// ****************************************
// reset values and exit code
// ****************************************
`define GATE_RST 1'b1
`define INVALID_EXIT 32'h0000_00ff
`endif

//--- hdl/guest_event_gating_injection.v
// global event gate, pending events and guest entry injection
// assumes instruction and event inputs are one-cycle pulses
//
// Contract
// RQ1: set/clear instructions set and clear the gate
// RQ2: breakpoint debug traps dropped while gate low
// RQ3: internal management interrupts dropped while gate low
// RQ4: restart, nmi, smi, interrupts held while gate low
// RQ5: trace, reset, a20, housekeeping ignore gate
// RQ6: machine check held if allowed, else shutdown
// RQ7: debug pin governed only by disable bit
// RQ8: address masking governed only by disable bit
// RQ9: security exception only when gate high
// RQ10: hypervisor call has no privilege check
// RQ11: unintercepted hypervisor call raises undefined fault
// RQ12: accept paged real mode image
// RQ13: valid injection taken before first instruction
// RQ14: injected event skips intercepts, secondaries checked
// RQ15: injected nmi does not set nmi blocking
// RQ16: impossible event aborts entry with invalid code
// RQ17: vector bits 7-0, type bits 10-8
// RQ18: bit 31 marks pending injection
// RQ19: decode types 0,2,3,4; nmi ignores vector
// RQ20: error value pushed only when valid bit set
// RQ21: vectors 3,4 of type 3 check descriptor level
// RQ22: reserved type or non-exception vector fails
// RQ23: held events delivered in priority once gate rises
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "gate_inject_consts.vh"

module guest_event_gating_injection (
   // clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // register port
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   // instructions
   input wire set_gate_instr_i,
   input wire clear_gate_instr_i,
   input wire hypervisor_call_instr_i,
   input wire guest_entry_instr_i,
   input wire resume_from_mgmt_instr_i,
   input wire nmi_return_i,
   // event sources
   input wire bp_match_i,
   input wire trace_flag_trap_i,
   input wire hw_reset_evt_i,
   input wire housekeeping_i,
   input wire restart_sig_i,
   input wire restart_redirect_i,
   input wire nmi_i,
   input wire ext_smi_i,
   input wire int_smi_i,
   input wire maskable_interrupt_i,
   input wire virtual_maskable_interrupt_i,
   input wire mcheck_i,
   input wire debug_request_pin_i,
   input wire address_bit20_mask_i,
   input wire guest_64bit_i,
   input wire delivery_fault_i,
   // event outputs
   output reg global_event_gate_o,
   output reg dbg_take_o,
   output reg trace_take_o,
   output reg reset_take_o,
   output reg housekeep_take_o,
   output reg restart_take_o,
   output reg security_exception_o,
   output reg smi_take_o,
   output reg nmi_take_o,
   output reg maskable_interrupt_take_o,
   output reg virtual_maskable_interrupt_take_o,
   output reg mcheck_take_o,
   output reg shutdown_o,
   output reg debug_enter_o,
   output reg a20_mask_o,
   // hypervisor call outputs
   output reg undefined_opcode_fault_o,
   output reg hcall_exit_o,
   // guest entry outputs
   output reg paged_real_o,
   output reg inj_deliver_o,
   output reg [2:0] inj_type_o,
   output reg [7:0] inj_vector_o,
   output reg inj_err_push_o,
   output reg [31:0] pushed_error_value_o,
   output reg inj_dpl_check_o,
   output reg inj_skip_icpt_o,
   output reg sec_exc_exit_o,
   output reg entry_fail_o,
   output reg [31:0] exit_code_o
);

   // ****************************************
   // functions
   // ****************************************
   function is_exc_vec;
      input [7:0] v;
      begin
         is_exc_vec = (v <= `VEC_EXC_MAX) && (v != `VEC_NMI) && (v != `VEC_RSVD);
      end
   endfunction

   function type_known;
      input [2:0] t;
      begin
         type_known = (t == `TYPE_MASKABLE_INTERRUPT) || (t == `TYPE_NMI) ||
            (t == `TYPE_EXC) || (t == `TYPE_SWINT);
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   reg [`CTRL_W-1:0] ctrl_r;
   reg [31:0] inj_lo_r;
   reg [31:0] inj_hi_r;
   reg [31:0] cr0_img_r;
   reg gate_r;
   reg nmi_blocked_r;
   reg gate_nxt;
   reg nmi_blocked_nxt;
   reg entry_fail_r;
   reg [5:0] pend_r;
   reg [5:0] pend_nxt;
   reg [5:0] take;
   reg mc_drop;

   wire [7:0] vec = inj_lo_r[`INJ_VEC_HI:`INJ_VEC_LO]; // RQ17
   wire [2:0] ityp = inj_lo_r[`INJ_TYPE_HI:`INJ_TYPE_LO]; // RQ17
   wire ivalid = inj_lo_r[`INJ_VALID]; // RQ18
   wire iev = inj_lo_r[`INJ_EV];
   wire cr0_prm = ~cr0_img_r[`CR0_PE] & cr0_img_r[`CR0_PG];
   wire type_bad = ~type_known(ityp) ||
      ((ityp == `TYPE_EXC) && ~is_exc_vec(vec)); // RQ22
   wire mode_bad = (ityp == `TYPE_EXC) && (vec == `VEC_BR) && guest_64bit_i; // RQ16
   wire inj_fail = ivalid && (type_bad || mode_bad);
   wire inj_nmi = (ityp == `TYPE_NMI); // RQ19
   wire inj_trap = (ityp == `TYPE_EXC) && ((vec == `VEC_BP) || (vec == `VEC_OF)); // RQ21

   // ****************************************
   // status word
   // ****************************************
   // bit 0 gate, 6:1 pending, 7 nmi blocked, 8 paged real, 9 entry failed, 10 shutdown
   wire [31:0] status_word = {
      21'h0,
      shutdown_o,
      entry_fail_r,
      paged_real_o,
      nmi_blocked_r,
      pend_r,
      gate_r
   };

   // new arrivals, in pending bit order
   wire [5:0] arrive = {
      virtual_maskable_interrupt_i,
      maskable_interrupt_i,
      nmi_i,
      ext_smi_i,
      restart_sig_i,
      mcheck_i
   };

   // ****************************************
   // pending events, priority order
   // ****************************************
   // bit 0 mcheck, 1 restart, 2 smi, 3 nmi, 4 maskable_interrupt, 5 virtual_maskable_interrupt
   always @* begin
      take = 6'h00;
      mc_drop = 1'b0;
      if (gate_r) begin
         if (pend_r[0])
            take = 6'h01; // RQ23
         else if (pend_r[1])
            take = 6'h02;
         else if (pend_r[2])
            take = 6'h04;
         else if (pend_r[3] && !nmi_blocked_r)
            take = 6'h08;
         else if (pend_r[4])
            take = 6'h10;
         else if (pend_r[5])
            take = 6'h20;
      end
      if (mcheck_i && !gate_r && !ctrl_r[`CTRL_MC_HOLD])
         mc_drop = 1'b1; // RQ6
      // new arrivals win over delivery clear
      pend_nxt = (pend_r & ~take) | (arrive & {5'h1f, ~mc_drop}); // RQ4 RQ6
   end

   // ****************************************
   // gate and nmi blocking next values
   // ****************************************
   // set wins over clear, a delivery wins over the return
   always @* begin
      gate_nxt = gate_r;
      nmi_blocked_nxt = nmi_blocked_r;
      if (set_gate_instr_i) begin
         gate_nxt = 1'b1; // RQ1
      end else if (clear_gate_instr_i) begin
         gate_nxt = 1'b0; // RQ1
      end
      if (take[3]) begin
         nmi_blocked_nxt = 1'b1;
      end else if (nmi_return_i) begin
         nmi_blocked_nxt = 1'b0;
      end
   end

   // ****************************************
   // gate and pending registers
   // ****************************************
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gate_r <= `GATE_RST;
         pend_r <= 6'h00;
         nmi_blocked_r <= 1'b0;
      end else begin
         gate_r <= gate_nxt;
         pend_r <= pend_nxt;
         nmi_blocked_r <= nmi_blocked_nxt; // RQ15
      end
   end

   // ****************************************
   // gated deliveries
   // ****************************************
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         global_event_gate_o <= `GATE_RST;
         dbg_take_o <= 1'b0;
         restart_take_o <= 1'b0;
         security_exception_o <= 1'b0;
         smi_take_o <= 1'b0;
         nmi_take_o <= 1'b0;
         maskable_interrupt_take_o <= 1'b0;
         virtual_maskable_interrupt_take_o <= 1'b0;
         mcheck_take_o <= 1'b0;
         shutdown_o <= 1'b0;
      end else begin
         global_event_gate_o <= gate_r;
         dbg_take_o <= bp_match_i & gate_r; // RQ2
         restart_take_o <= take[1] & ~restart_redirect_i; // RQ4
         security_exception_o <= take[1] & restart_redirect_i; // RQ9
         smi_take_o <= take[2] | (int_smi_i & gate_r); // RQ3
         nmi_take_o <= take[3];
         maskable_interrupt_take_o <= take[4];
         virtual_maskable_interrupt_take_o <= take[5];
         mcheck_take_o <= take[0];
         if (mc_drop)
            shutdown_o <= 1'b1; // RQ6
      end
   end

   // ****************************************
   // events that ignore the gate
   // ****************************************
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         trace_take_o <= 1'b0;
         reset_take_o <= 1'b0;
         housekeep_take_o <= 1'b0;
         debug_enter_o <= 1'b0;
         a20_mask_o <= 1'b0;
      end else begin
         trace_take_o <= trace_flag_trap_i; // RQ5
         reset_take_o <= hw_reset_evt_i; // RQ5
         housekeep_take_o <= housekeeping_i; // RQ5
         debug_enter_o <= debug_request_pin_i & ~ctrl_r[`CTRL_DPD]; // RQ7
         a20_mask_o <= address_bit20_mask_i & ~ctrl_r[`CTRL_DIS_ADDRESS_BIT20_MASK]; // RQ8 RQ5
      end
   end

   // ****************************************
   // hypervisor call
   // ****************************************
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         undefined_opcode_fault_o <= 1'b0;
         hcall_exit_o <= 1'b0;
      end else begin
         // no privilege level is consulted here
         undefined_opcode_fault_o <= hypervisor_call_instr_i &
            ~ctrl_r[`CTRL_HCALL_ICPT]; // RQ10 RQ11
         hcall_exit_o <= hypervisor_call_instr_i & ctrl_r[`CTRL_HCALL_ICPT]; // RQ10
      end
   end

   // ****************************************
   // guest entry and injection
   // ****************************************
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         paged_real_o <= 1'b0;
         inj_deliver_o <= 1'b0;
         inj_type_o <= 3'h0;
         inj_vector_o <= 8'h00;
         inj_err_push_o <= 1'b0;
         pushed_error_value_o <= 32'h0000_0000;
         inj_dpl_check_o <= 1'b0;
         inj_skip_icpt_o <= 1'b0;
         sec_exc_exit_o <= 1'b0;
         entry_fail_o <= 1'b0;
         entry_fail_r <= 1'b0;
         exit_code_o <= 32'h0000_0000;
      end else begin
         inj_deliver_o <= 1'b0;
         inj_skip_icpt_o <= 1'b0;
         inj_err_push_o <= 1'b0;
         inj_dpl_check_o <= 1'b0;
         entry_fail_o <= 1'b0;
         sec_exc_exit_o <= delivery_fault_i & ctrl_r[`CTRL_EXC_ICPT]; // RQ14
         if (guest_entry_instr_i || resume_from_mgmt_instr_i)
            paged_real_o <= cr0_prm; // RQ12
         if (guest_entry_instr_i) begin
            entry_fail_r <= inj_fail;
            if (inj_fail) begin
               entry_fail_o <= 1'b1; // RQ16 RQ22
               exit_code_o <= `INVALID_EXIT; // RQ16
            end else if (ivalid) begin
               inj_deliver_o <= 1'b1; // RQ13 RQ18
               inj_skip_icpt_o <= 1'b1; // RQ14
               inj_type_o <= ityp; // RQ19
               inj_vector_o <= inj_nmi ? 8'h00 : vec; // RQ19
               inj_err_push_o <= iev; // RQ20
               pushed_error_value_o <= iev ? inj_hi_r : 32'h0000_0000; // RQ20
               inj_dpl_check_o <= inj_trap; // RQ21
            end
         end
      end
   end
   // injected nmi leaves nmi_blocked_r untouched: RQ15

   // ****************************************
   // register port
   // ****************************************
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_r <= `CTRL_RST;
         inj_lo_r <= 32'h0000_0000;
         inj_hi_r <= 32'h0000_0000;
         cr0_img_r <= 32'h0000_0000;
         rdata_o <= 32'h0000_0000;
      end else begin
         if (wr_i) begin
            case (addr_i)
               `OFF_CTRL: ctrl_r <= wdata_i[`CTRL_W-1:0];
               `OFF_INJ_LO: inj_lo_r <= wdata_i;
               `OFF_INJ_HI: inj_hi_r <= wdata_i;
               `OFF_CR0_IMG: cr0_img_r <= wdata_i;
               default: ;
            endcase
         end
         if (rd_i) begin
            case (addr_i)
               `OFF_CTRL: rdata_o <= {27'h0, ctrl_r};
               `OFF_INJ_LO: rdata_o <= inj_lo_r;
               `OFF_INJ_HI: rdata_o <= inj_hi_r;
               `OFF_CR0_IMG: rdata_o <= cr0_img_r;
               `OFF_STATUS: rdata_o <= status_word;
               `OFF_EXIT: rdata_o <= exit_code_o;
               default: rdata_o <= 32'h0000_0000;
            endcase
         end else begin
            rdata_o <= 32'h0000_0000;
         end
      end
   end

endmodule // guest_event_gating_injection
